// ### logic/pcog_params.svh
// register offsets, field positions and reset values of the clock output generator
`ifndef PCOG_PARAMS_SVH
`define PCOG_PARAMS_SVH
`define PCOG_DIVIDER_SETUP_ADDR 8'h8F
`define PCOG_PIN_CLOCK_SETUP_ADDR 8'hB6
`define PCOG_DIVIDER_SETUP_RESET 8'h00
`define PCOG_PIN_CLOCK_SETUP_RESET 8'h00
`define PCOG_BIT_CLEAR 7
`define PCOG_BIT_INVERT 6
`define PCOG_BIT_BALANCED 5
`define PCOG_DIV_MSB 4
`define PCOG_DIV_LSB 0
`define PCOG_BIT_PIN6 5
`define PCOG_BIT_PIN4 4
`define PCOG_BIT_ENABLE 3
`define PCOG_BIT_REFEN 2
`define PCOG_BIT_IRQB_EDGE 7
`define PCOG_BIT_IRQA_EDGE 6
`define PCOG_PIN_WRITE_MASK 8'hFC
`define PCOG_SYNC_STAGES 2
`endif

// ### logic/pcog_pkg.sv
// types of the clock output generator
package pcog_pkg;
   typedef logic [4:0] pcog_div_t;
   typedef enum logic [2:0] {
      PCOG_IDLE = 3'h1,
      PCOG_RUN = 3'h2,
      PCOG_BYPASS = 3'h4
   } pcog_state_t;
endpackage

// ### logic/pcog_sync.sv
// two flip-flop level synchroniser, one bit
`timescale 1ns/10ps
`default_nettype none
module pcog_sync (
   input wire logic clk_sys_in,   // oscillator clock
   input wire logic resetn_in,    // synchronous reset, active low
   input wire logic level_in,     // level to carry over
   output logic level_out         // synchronised level
);
   logic stage_a;
   logic stage_b;
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         stage_a <= 1'b0;
         stage_b <= 1'b0;
      end else begin
         stage_a <= level_in;
         stage_b <= stage_a;
      end
   end
   assign level_out = stage_b;
endmodule
`default_nettype wire

// ### logic/pcog_divider.sv
// divider core: counts oscillator cycles and shapes the generated clock
`timescale 1ns/10ps
`default_nettype none
`include "pcog_params.svh"
module pcog_divider (
   input wire logic clk_sys_in,          // 24 MHz oscillator clock
   input wire logic resetn_in,           // synchronous reset, active low
   input wire logic enable_in,           // master clock enable
   input wire logic clear_in,            // one-cycle clear pulse
   input wire logic balanced_in,         // balanced duty select
   input wire pcog_pkg::pcog_div_t div_in, // requested division factor
   output logic wave_out,                // generated clock before inversion
   output logic idle_out                 // no period running
);
   pcog_pkg::pcog_state_t state;
   pcog_pkg::pcog_state_t next_state;
   pcog_pkg::pcog_div_t ratio;
   pcog_pkg::pcog_div_t next_ratio;
   pcog_pkg::pcog_div_t count;
   pcog_pkg::pcog_div_t next_count;
   logic rise_ff;
   logic next_rise_ff;
   logic fall_ff;
   logic next_fall_ff;
   logic bypass_ok;
   pcog_pkg::pcog_div_t low_len;

   assign bypass_ok = (div_in <= 5'h01);
   // low part is floor(n/2), high part ceil(n/2)
   assign low_len = pcog_pkg::pcog_div_t'(ratio >> 1);

   always_comb begin
      next_state = state;
      next_ratio = ratio;
      next_count = count;
      next_rise_ff = rise_ff;
      next_fall_ff = fall_ff;
      case (state)
         pcog_pkg::PCOG_IDLE: begin
            next_rise_ff = 1'b0;
            next_count = 5'h00;
            if (enable_in) begin
               next_ratio = div_in;
               next_state = bypass_ok ? pcog_pkg::PCOG_BYPASS : pcog_pkg::PCOG_RUN;
            end
         end
         pcog_pkg::PCOG_RUN: begin
            if (count == ratio - 5'h01) begin
               // period boundary: take new factor or stop low
               next_count = 5'h00;
               next_rise_ff = 1'b0;
               next_ratio = div_in;
               if (!enable_in) begin
                  next_state = pcog_pkg::PCOG_IDLE;
               end else if (bypass_ok) begin
                  next_state = pcog_pkg::PCOG_BYPASS;
               end
            end else begin
               next_count = count + 5'h01;
               if (count == low_len - 5'h01) begin
                  next_rise_ff = 1'b1;
               end
            end
         end
         pcog_pkg::PCOG_BYPASS: begin
            next_ratio = div_in;
            if (!enable_in) begin
               next_state = pcog_pkg::PCOG_IDLE;
            end else if (!bypass_ok) begin
               next_state = pcog_pkg::PCOG_RUN;
            end
         end
         default: begin
            next_state = pcog_pkg::PCOG_IDLE;
         end
      endcase
      // one-cycle later copy of the rise flop for odd ratios
      next_fall_ff = (state == pcog_pkg::PCOG_RUN) ? rise_ff : 1'b0;
      if (clear_in) begin
         next_state = pcog_pkg::PCOG_IDLE;
         next_count = 5'h00;
         next_rise_ff = 1'b0;
         next_fall_ff = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         state <= pcog_pkg::PCOG_IDLE;
         ratio <= 5'h00;
         count <= 5'h00;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end else begin
         state <= next_state;
         ratio <= next_ratio;
         count <= next_count;
         rise_ff <= next_rise_ff;
         fall_ff <= next_fall_ff;
      end
   end

   // odd ratio balanced: widen low by sharing one cycle via the later flop
   always_comb begin
      if (state == pcog_pkg::PCOG_BYPASS) begin
         wave_out = clk_sys_in;
      end else if (balanced_in && ratio[0]) begin
         wave_out = rise_ff & fall_ff;
      end else begin
         wave_out = rise_ff;
      end
   end
   assign idle_out = (state != pcog_pkg::PCOG_RUN);
endmodule
`default_nettype wire

// ### logic/pcog_top.sv
// programmable clock output generator: registers, sync, divider and pin routing
// Summary of operation
// - Output clock comes only from the 24 MHz oscillator, not system divider.
// - Integer division factors 1 to 31 are supported.
// - Factor 0 or 1 passes the oscillator clock straight through.
// - Unbalanced odd ratio: low part one cycle shorter than high part.
// - Balanced option keeps duty near 1:1, odd ratios included.
// - New factor applies at the end of the running period, after a clear, or at once in bypass.
// - Clearing enable finishes the period then holds output low.
// - Pin bits route clock to GPIO 4 and/or 6; enable gates waveform only.
// - Reference select forces GPIO 3 to input and uses it as reference.
// - Writing clear resets the divider and forces output low at once.
// - Clear bit reads one when idle, zero while a period runs.
// - Clear written with a new factor switches ratio immediately.
// - Invert is the final stage; disabled output rests high when set.
// - Invert change takes effect immediately, glitch possible.
`timescale 1ns/10ps
`default_nettype none
`include "pcog_params.svh"
module pcog_top (
   input wire logic clk_sys_in,       // 24 MHz oscillator clock
   input wire logic resetn_in,        // synchronous reset, active low
   input wire logic sfr_wr_in,        // register write strobe
   input wire logic sfr_rd_in,        // register read strobe
   input wire logic [7:0] sfr_addr_in, // register address
   input wire logic [7:0] sfr_wdata_in, // write data
   input wire logic gpio3_pad_in,     // level seen on GPIO 3
   output logic [7:0] sfr_rdata_out,  // read data
   output logic sfr_hit_out,          // address belongs to this block
   output logic clk_gen_out,          // generated clock after inversion
   output logic gpio4_clk_sel_out,    // GPIO 4 carries the clock
   output logic gpio4_clk_out,        // clock level for GPIO 4
   output logic gpio6_clk_sel_out,    // GPIO 6 carries the clock
   output logic gpio6_clk_out,        // clock level for GPIO 6
   output logic gpio3_force_in_out,   // GPIO 3 forced to input
   output logic clk_ref_out,          // reference clock from GPIO 3
   output logic ext_irq_a_edge_mode_out, // edge mode, external irq a
   output logic ext_irq_b_edge_mode_out  // edge mode, external irq b
);
   logic [6:0] divider_setup;
   logic [6:0] next_divider_setup;
   logic [7:0] pin_clock_setup;
   logic [7:0] next_pin_clock_setup;
   logic clear_req;
   logic next_clear_req;
   logic wr_div;
   logic wr_pin;
   logic enable_s;
   logic clear_s;
   logic clear_s_d;
   logic clear_pulse;
   logic idle;
   logic wave;
   logic [4:0] div_s;
   pcog_pkg::pcog_div_t div_sync;

   assign wr_div = sfr_wr_in && (sfr_addr_in == `PCOG_DIVIDER_SETUP_ADDR);
   assign wr_pin = sfr_wr_in && (sfr_addr_in == `PCOG_PIN_CLOCK_SETUP_ADDR);

   always_comb begin
      next_divider_setup = divider_setup;
      next_pin_clock_setup = pin_clock_setup;
      next_clear_req = clear_req;
      if (wr_div) begin
         next_divider_setup = sfr_wdata_in[6:0];
      end
      if (wr_pin) begin
         next_pin_clock_setup = sfr_wdata_in & `PCOG_PIN_WRITE_MASK;
      end
      // clear request toggles so a one-cycle write survives the crossing
      if (wr_div && sfr_wdata_in[`PCOG_BIT_CLEAR]) begin
         next_clear_req = ~clear_req;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         divider_setup <= 7'h00;
         pin_clock_setup <= `PCOG_PIN_CLOCK_SETUP_RESET;
         clear_req <= 1'b0;
         clear_s_d <= 1'b0;
      end else begin
         divider_setup <= next_divider_setup;
         pin_clock_setup <= next_pin_clock_setup;
         clear_req <= next_clear_req;
         clear_s_d <= clear_s;
      end
   end

   pcog_sync u_sync_en (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .level_in(pin_clock_setup[`PCOG_BIT_ENABLE]),
      .level_out(enable_s)
   );
   pcog_sync u_sync_clr (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .level_in(clear_req),
      .level_out(clear_s)
   );
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_div_sync
         pcog_sync u_sync_div (
            .clk_sys_in(clk_sys_in),
            .resetn_in(resetn_in),
            .level_in(divider_setup[gi]),
            .level_out(div_s[gi])
         );
      end
   endgenerate
   assign div_sync = div_s;
   assign clear_pulse = clear_s ^ clear_s_d;

   pcog_divider u_divider (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .enable_in(enable_s),
      .clear_in(clear_pulse),
      .balanced_in(divider_setup[`PCOG_BIT_BALANCED]),
      .div_in(div_sync),
      .wave_out(wave),
      .idle_out(idle)
   );

   // inversion last, straight from the register: immediate effect
   assign clk_gen_out = wave ^ divider_setup[`PCOG_BIT_INVERT];
   assign gpio4_clk_sel_out = pin_clock_setup[`PCOG_BIT_PIN4];
   assign gpio6_clk_sel_out = pin_clock_setup[`PCOG_BIT_PIN6];
   assign gpio4_clk_out = clk_gen_out;
   assign gpio6_clk_out = clk_gen_out;
   assign gpio3_force_in_out = pin_clock_setup[`PCOG_BIT_REFEN];
   assign clk_ref_out = pin_clock_setup[`PCOG_BIT_REFEN] & gpio3_pad_in;
   assign ext_irq_a_edge_mode_out = pin_clock_setup[`PCOG_BIT_IRQA_EDGE];
   assign ext_irq_b_edge_mode_out = pin_clock_setup[`PCOG_BIT_IRQB_EDGE];

   always_comb begin
      sfr_hit_out = 1'b0;
      sfr_rdata_out = 8'h00;
      if (sfr_addr_in == `PCOG_DIVIDER_SETUP_ADDR) begin
         sfr_hit_out = 1'b1;
         sfr_rdata_out = {idle, divider_setup};
      end else if (sfr_addr_in == `PCOG_PIN_CLOCK_SETUP_ADDR) begin
         sfr_hit_out = 1'b1;
         sfr_rdata_out = pin_clock_setup;
      end
   end

   sequence s_disable_seen;
      !pin_clock_setup[`PCOG_BIT_ENABLE];
   endsequence

   a_idle_after_disable: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      s_disable_seen [*8] |-> ##[0:40] idle)
      else $error("divider not idle after disable");
   a_clear_forces_low: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      clear_pulse |=> (idle && !u_divider.rise_ff))
      else $error("clear did not stop divider");
   a_invert_final: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      idle |-> (clk_gen_out == divider_setup[`PCOG_BIT_INVERT]))
      else $error("idle output level wrong");
   a_pin_route_4: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      wr_pin |=> (gpio4_clk_sel_out == $past(sfr_wdata_in[`PCOG_BIT_PIN4])))
      else $error("pin 4 route not taken");
   a_ref_forced: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      gpio3_force_in_out |-> (clk_ref_out == gpio3_pad_in))
      else $error("reference not from pad");
   a_idle_read: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (sfr_addr_in == `PCOG_DIVIDER_SETUP_ADDR) |-> (sfr_rdata_out[7] == idle))
      else $error("idle read mismatch");
   a_enable_synced: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(pin_clock_setup[`PCOG_BIT_ENABLE]) |-> ##2 enable_s)
      else $error("enable not synchronised in two cycles");
   a_low_bits_zero: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      pin_clock_setup[1:0] == 2'h0)
      else $error("reserved bits set");
endmodule
`default_nettype wire

// ### testbench/pcog_clock_sink.sv
// partner chip model: measures high and low runs of the received clock
`timescale 1ns/10ps
`default_nettype none
module pcog_clock_sink (
   input wire logic clk_sys_in,     // oscillator clock used as ruler
   input wire logic clk_rx_in,      // received clock
   output logic [7:0] high_len_out, // cycles of last high run
   output logic [7:0] low_len_out   // cycles of last low run
);
   logic prev = 1'b0;
   logic [7:0] run = 8'h00;
   initial begin
      high_len_out = 8'h00;
      low_len_out = 8'h00;
   end
   always @(posedge clk_sys_in) begin
      if (clk_rx_in === prev) begin
         run <= run + 8'h01;
      end else begin
         if (prev) high_len_out <= run;
         else low_len_out <= run;
         run <= 8'h01;
      end
      prev <= clk_rx_in;
   end
endmodule
`default_nettype wire

// ### testbench/test_programmable_clock_output_generator.sv
// self-checking bench of the clock output generator
`timescale 1ns/10ps
`default_nettype none
module test_programmable_clock_output_generator;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, pad = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, hi, lo;
   logic hit, gen, s4, c4, s6, c6, f3, rf, ea, eb;
   int fail_count = 0, n_compared = 0;
   pcog_top dut (.clk_sys_in(clk), .resetn_in(rstn), .sfr_wr_in(wr), .sfr_rd_in(rd),
      .sfr_addr_in(addr), .sfr_wdata_in(wdata), .gpio3_pad_in(pad), .sfr_rdata_out(rdata),
      .sfr_hit_out(hit), .clk_gen_out(gen), .gpio4_clk_sel_out(s4), .gpio4_clk_out(c4),
      .gpio6_clk_sel_out(s6), .gpio6_clk_out(c6), .gpio3_force_in_out(f3),
      .clk_ref_out(rf), .ext_irq_a_edge_mode_out(ea), .ext_irq_b_edge_mode_out(eb));
   pcog_clock_sink sink (.clk_sys_in(clk), .clk_rx_in(c4), .high_len_out(hi),
      .low_len_out(lo));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      #1 v = rdata;
      rd = 1'b0;
   endtask
   task automatic wait_idle();
      logic [7:0] v;
      for (int i = 0; i < 100; i++) begin
         rd_reg(8'h8F, v);
         if (v[7] === 1'b1) break;
      end
      chk("idle flag", 8'h01, {7'h00, v[7]});
   endtask
   task automatic t_reset();
      logic [7:0] v;
      rd_reg(8'h8F, v);
      chk("divider_setup", 8'h80, v);
      chk("hit mapped", 8'h01, {7'h00, hit});
      rd_reg(8'hB6, v);
      chk("pin_clock_setup", 8'h00, v);
      rd_reg(8'h55, v);
      chk("unmapped", 8'h00, v);
      chk("hit", 8'h00, {7'h00, hit});
      $display("test reset done");
   endtask
   task automatic t_pins();
      logic [7:0] v;
      pad = 1'b1;
      wr_reg(8'hB6, 8'hF7);
      rd_reg(8'hB6, v);
      chk("pin_clock_setup", 8'hF4, v);
      chk("pin selects", 8'h03, {6'h00, s6, s4});
      chk("edge modes", 8'h03, {6'h00, eb, ea});
      chk("ref path", 8'h03, {6'h00, f3, rf});
      pad = 1'b0;
      #1 chk("ref low", 8'h00, {7'h00, rf});
      wr_reg(8'hB6, 8'h00);
      $display("test pins done");
   endtask
   task automatic t_div(input logic [4:0] n);
      wr_reg(8'h8F, {3'h0, n});
      wr_reg(8'hB6, 8'h18);
      repeat (3 * n + 10) @(negedge clk);
      chk("low run", 8'(n / 2), lo);
      chk("high run", 8'(n - n / 2), hi);
      chk("gpio6 copy", {7'h00, gen}, {7'h00, c6});
      wr_reg(8'hB6, 8'h10);
      wait_idle();
      repeat (4) @(negedge clk);
      chk("stopped level", 8'h02, {6'h00, s4, gen});
      $display("test divide by %0d done", n);
   endtask
   task automatic t_bal();
      wr_reg(8'h8F, 8'h25);
      wr_reg(8'hB6, 8'h18);
      repeat (25) @(negedge clk);
      chk("balanced period", 8'h05, hi + lo);
      chk("balanced skew", 8'h01, 8'(hi - lo + 8'h01 <= 8'h02));
      wr_reg(8'hB6, 8'h10);
      wait_idle();
      wr_reg(8'h8F, 8'h45);
      #1 chk("inverted rest", 8'h01, {7'h00, gen});
      wr_reg(8'h8F, 8'h00);
      $display("test balanced done");
   endtask
   task automatic t_clear();
      logic [7:0] v;
      wr_reg(8'h8F, 8'h1F);
      wr_reg(8'hB6, 8'h18);
      repeat (20) @(negedge clk);
      rd_reg(8'h8F, v);
      chk("busy flag", 8'h00, {7'h00, v[7]});
      wr_reg(8'h8F, 8'h83);
      repeat (20) @(negedge clk);
      chk("new low run", 8'h01, lo);
      chk("new high run", 8'h02, hi);
      wr_reg(8'hB6, 8'h10);
      wait_idle();
      $display("test clear done");
   endtask
   task automatic t_bypass();
      wr_reg(8'h8F, 8'h01);
      wr_reg(8'hB6, 8'h18);
      repeat (6) @(negedge clk);
      @(posedge clk);
      #1.25 chk("bypass high", 8'h01, {7'h00, gen});
      @(negedge clk);
      #1.25 chk("bypass low", 8'h00, {7'h00, gen});
      wait_idle();
      wr_reg(8'hB6, 8'h00);
      $display("test bypass done");
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      t_reset();
      t_pins();
      t_div(5'h02);
      t_div(5'h05);
      t_div(5'h1F);
      t_bal();
      t_clear();
      t_bypass();
      report_and_stop();
   end
endmodule
`default_nettype wire
